// ### rtl/asm_pkg.sv
// Package for the alarm and status monitor: offsets, fields, resets and carriers
package asm_pkg;

    // ****************************************************************
    // Register byte addresses (low and high byte of each 16-bit register; command low byte only)
    // ****************************************************************
    localparam logic [6:0] ADDR_THRESH_ONE_LO = 7'h20;
    localparam logic [6:0] ADDR_THRESH_ONE_HI = 7'h21;
    localparam logic [6:0] ADDR_THRESH_TWO_LO = 7'h22;
    localparam logic [6:0] ADDR_THRESH_TWO_HI = 7'h23;
    localparam logic [6:0] ADDR_ALARM_CTRL_LO = 7'h28;
    localparam logic [6:0] ADDR_ALARM_CTRL_HI = 7'h29;
    localparam logic [6:0] ADDR_ERROR_FLAGS_LO = 7'h3c;
    localparam logic [6:0] ADDR_ERROR_FLAGS_HI = 7'h3d;
    localparam logic [6:0] ADDR_COMMAND_LO = 7'h3e;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] RST_THRESH = 16'h0000;
    localparam logic [15:0] RST_ALARM_CTRL = 16'h0000;
    localparam logic [15:0] RST_ERROR_FLAGS = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CMD_CLEAR_FLAGS_BIT = 4;
    localparam int CTRL_SRC_TWO_LSB = 12;
    localparam int CTRL_SRC_ONE_LSB = 8;
    localparam int CTRL_CAPT_TWO_BIT = 6;
    localparam int CTRL_CAPT_ONE_BIT = 4;
    localparam int CTRL_IND_EN_BIT = 2;
    localparam int CTRL_IND_POL_BIT = 1;
    localparam int CTRL_IND_LINE_BIT = 0;
    localparam int THR_POLARITY_BIT = 15;
    localparam int THR_LEVEL_MSB = 13;
    localparam int ST_SUPPLY_LOW_BIT = 0;
    localparam int ST_SUPPLY_HIGH_BIT = 1;
    localparam int ST_FLASH_FAIL_BIT = 2;
    localparam int ST_SERIAL_FAIL_BIT = 3;
    localparam int ST_SELF_TEST_BIT = 5;
    localparam int ST_ALARM_ONE_BIT = 8;
    localparam int ST_ALARM_TWO_BIT = 9;
    localparam int ST_BUF_FULL_BIT = 12;

    // ****************************************************************
    // Alarm source codes
    // ****************************************************************
    typedef enum logic [3:0] {
        SRC_OFF = 4'h0,
        SRC_SUPPLY = 4'h1,
        SRC_X = 4'h2,
        SRC_Y = 4'h3,
        SRC_AUX = 4'h4,
        SRC_TEMP = 4'h5,
        SRC_RSS = 4'h8
    } asm_source_t;

    // Measurement channels, one sample each
    typedef struct packed {
        logic [13:0] supply;
        logic [13:0] accelX;
        logic [13:0] accelY;
        logic [13:0] aux;
        logic [13:0] temp;
        logic [13:0] rss;
    } asm_samples_t;

    // Error conditions from neighbouring logic, same clock, levels
    typedef struct packed {
        logic bufferFull;
        logic selfTestFail;
        logic serialFail;
        logic flashFail;
    } asm_errors_t;

endpackage

// ### rtl/asm_alarm_status.sv
// Alarm comparators, status flags, alarm indicator and capture triggers
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Status word holds alarm and error flags
// - Bit1 supply above 3.625V, bit0 below 2.975V
// - Supply flags clear themselves when condition ends
// - Command bit 4 write clears other flags
// - Persisting condition re-sets flag next sample
// - Status read-only, volatile, resets to zero
// - Status bit positions 12,9,8,5,3,2,1,0; rest zero
// - Control nibbles select each alarm's source
// - Threshold bit15 polarity, bits 13:0 level
// - Control bits 6,4 enable capture triggers
// - Control bits 2,1,0: indicator enable, polarity, line
// - Trigger source independent of captured channels
// - Line priority: gpio, data-ready, then alarm
module asm_alarm_status (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic regWrite,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [15:0] regRdData,
    input wire logic sampleStrobe,
    input wire asm_pkg::asm_samples_t samples,
    input wire asm_pkg::asm_errors_t errors,
    input wire logic supplyHighPin,
    input wire logic supplyLowPin,
    input wire logic [1:0] gpioOwnsLine,
    input wire logic [1:0] readyOwnsLine,
    output logic [1:0] alarmLineOut,
    output logic [1:0] alarmLineOe,
    output logic captureTrigOne,
    output logic captureTrigTwo
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] threshOne_q, threshOne_d;
    logic [15:0] threshTwo_q, threshTwo_d;
    logic [15:0] alarmCtrl_q, alarmCtrl_d;
    logic clearFlags;

    // Byte writes land in one half at a time; a word takes two writes
    always_comb begin
        threshOne_d = threshOne_q;
        threshTwo_d = threshTwo_q;
        alarmCtrl_d = alarmCtrl_q;
        clearFlags = 1'b0;
        if (regWrite) begin
            case (regAddr)
                asm_pkg::ADDR_THRESH_ONE_LO: threshOne_d[7:0] = regWrData;
                asm_pkg::ADDR_THRESH_ONE_HI: threshOne_d[15:8] = regWrData;
                asm_pkg::ADDR_THRESH_TWO_LO: threshTwo_d[7:0] = regWrData;
                asm_pkg::ADDR_THRESH_TWO_HI: threshTwo_d[15:8] = regWrData;
                asm_pkg::ADDR_ALARM_CTRL_LO: alarmCtrl_d[7:0] = regWrData;
                asm_pkg::ADDR_ALARM_CTRL_HI: alarmCtrl_d[15:8] = regWrData;
                asm_pkg::ADDR_COMMAND_LO: clearFlags = regWrData[asm_pkg::CMD_CLEAR_FLAGS_BIT];
                default: clearFlags = 1'b0; // Status and unknown addresses ignore writes
            endcase
        end
    end

    // Configuration storage
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            threshOne_q <= asm_pkg::RST_THRESH;
            threshTwo_q <= asm_pkg::RST_THRESH;
            alarmCtrl_q <= asm_pkg::RST_ALARM_CTRL;
        end else begin
            threshOne_q <= threshOne_d;
            threshTwo_q <= threshTwo_d;
            alarmCtrl_q <= alarmCtrl_d;
        end
    end

    // ****************************************************************
    // Supply comparator synchronisers
    // ****************************************************************
    logic [1:0] supplyMeta_q, supplySync_q;

    // Comparators are analog and asynchronous to clk_sys
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            supplyMeta_q <= 2'h0;
            supplySync_q <= 2'h0;
        end else begin
            supplyMeta_q <= {supplyHighPin, supplyLowPin};
            supplySync_q <= supplyMeta_q;
        end
    end

    // ****************************************************************
    // Alarm comparators, one per alarm
    // ****************************************************************
    logic [1:0] alarmHit;

    for (genvar i = 0; i < 2; i++) begin : gAlarm
        logic [3:0] srcSel;
        logic [15:0] thr;
        logic [13:0] value;
        logic enabled;
        assign srcSel = (i == 0) ? alarmCtrl_q[asm_pkg::CTRL_SRC_ONE_LSB +: 4]
                                 : alarmCtrl_q[asm_pkg::CTRL_SRC_TWO_LSB +: 4];
        assign thr = (i == 0) ? threshOne_q : threshTwo_q;

        // Source mux; unlisted codes behave as disabled
        always_comb begin
            value = 14'h0000;
            enabled = 1'b1;
            case (srcSel)
                asm_pkg::SRC_SUPPLY: value = samples.supply;
                asm_pkg::SRC_X: value = samples.accelX;
                asm_pkg::SRC_Y: value = samples.accelY;
                asm_pkg::SRC_AUX: value = samples.aux;
                asm_pkg::SRC_TEMP: value = samples.temp;
                asm_pkg::SRC_RSS: value = samples.rss;
                default: enabled = 1'b0;
            endcase
        end

        // Bit 14 ignored; unsigned compare of the 14-bit level
        assign alarmHit[i] = enabled && (thr[asm_pkg::THR_POLARITY_BIT]
            ? (value > thr[asm_pkg::THR_LEVEL_MSB:0])
            : (value < thr[asm_pkg::THR_LEVEL_MSB:0]));
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    logic [15:0] status_q, status_d;
    logic [1:0] alarmLive_q, alarmLive_d;

    // Sticky flags: set on a sample beats a clear in the same cycle
    always_comb begin
        status_d = status_q;
        alarmLive_d = alarmLive_q;
        if (clearFlags) begin
            status_d = 16'h0000;
        end
        if (sampleStrobe) begin
            alarmLive_d = alarmHit;
            if (alarmHit[0]) status_d[asm_pkg::ST_ALARM_ONE_BIT] = 1'b1;
            if (alarmHit[1]) status_d[asm_pkg::ST_ALARM_TWO_BIT] = 1'b1;
            if (errors.bufferFull) status_d[asm_pkg::ST_BUF_FULL_BIT] = 1'b1;
            if (errors.selfTestFail) status_d[asm_pkg::ST_SELF_TEST_BIT] = 1'b1;
            if (errors.serialFail) status_d[asm_pkg::ST_SERIAL_FAIL_BIT] = 1'b1;
            if (errors.flashFail) status_d[asm_pkg::ST_FLASH_FAIL_BIT] = 1'b1;
        end
        // Supply bits follow the comparators directly, never sticky
        status_d[asm_pkg::ST_SUPPLY_HIGH_BIT] = supplySync_q[1];
        status_d[asm_pkg::ST_SUPPLY_LOW_BIT] = supplySync_q[0];
    end

    // Status storage, volatile
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= asm_pkg::RST_ERROR_FLAGS;
            alarmLive_q <= 2'h0;
        end else begin
            status_q <= status_d;
            alarmLive_q <= alarmLive_d;
        end
    end

    // ****************************************************************
    // Indicator line, capture triggers, read port
    // ****************************************************************
    logic [1:0] lineOut_q, lineOut_d, lineOe_q, lineOe_d;
    logic trigOne_q, trigOne_d, trigTwo_q, trigTwo_d;
    logic [15:0] rdData_q, rdData_d;
    logic anyAlarm, activeLevel;
    logic [1:0] lineFree;

    assign anyAlarm = |alarmLive_q;
    assign activeLevel = alarmCtrl_q[asm_pkg::CTRL_IND_POL_BIT];
    assign lineFree = ~(gpioOwnsLine | readyOwnsLine);

    // Indicator drives only a free line; the owners drive it otherwise
    always_comb begin
        lineOut_d = 2'h0;
        lineOe_d = 2'h0;
        for (int k = 0; k < 2; k++) begin
            if (alarmCtrl_q[asm_pkg::CTRL_IND_EN_BIT]
                && (alarmCtrl_q[asm_pkg::CTRL_IND_LINE_BIT] == k[0]) && lineFree[k]) begin
                lineOe_d[k] = 1'b1;
                lineOut_d[k] = anyAlarm ? activeLevel : ~activeLevel;
            end
        end
        // Trigger does not depend on which channels are captured
        trigOne_d = alarmLive_q[0] & alarmCtrl_q[asm_pkg::CTRL_CAPT_ONE_BIT];
        trigTwo_d = alarmLive_q[1] & alarmCtrl_q[asm_pkg::CTRL_CAPT_TWO_BIT];
        case (regAddr)
            asm_pkg::ADDR_THRESH_ONE_LO, asm_pkg::ADDR_THRESH_ONE_HI: rdData_d = threshOne_q;
            asm_pkg::ADDR_THRESH_TWO_LO, asm_pkg::ADDR_THRESH_TWO_HI: rdData_d = threshTwo_q;
            asm_pkg::ADDR_ALARM_CTRL_LO, asm_pkg::ADDR_ALARM_CTRL_HI: rdData_d = alarmCtrl_q;
            asm_pkg::ADDR_ERROR_FLAGS_LO, asm_pkg::ADDR_ERROR_FLAGS_HI: rdData_d = status_q;
            default: rdData_d = 16'h0000;
        endcase
    end

    // Output registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lineOut_q <= 2'h0;
            lineOe_q <= 2'h0;
            trigOne_q <= 1'b0;
            trigTwo_q <= 1'b0;
            rdData_q <= 16'h0000;
        end else begin
            lineOut_q <= lineOut_d;
            lineOe_q <= lineOe_d;
            trigOne_q <= trigOne_d;
            trigTwo_q <= trigTwo_d;
            rdData_q <= rdData_d;
        end
    end

    assign alarmLineOut = lineOut_q;
    assign alarmLineOe = lineOe_q;
    assign captureTrigOne = trigOne_q;
    assign captureTrigTwo = trigTwo_q;
    assign regRdData = rdData_q;

endmodule

`default_nettype wire

// ### test/asm_host_model.sv
// Host processor model driving the byte-write, word-read register port
`timescale 1ns/1ns
`default_nettype none
module asm_host_model (
    input wire logic clk_sys,
    output logic regWrite,
    output logic [6:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [15:0] regRdData
);
    // ****************************************
    // Bus tasks
    // ****************************************
    // Idle bus at time zero
    initial begin
        regWrite = 1'b0;
        regAddr = 7'h00;
        regWrData = 8'h00;
    end
    // One byte; released data is inverted so stale bytes never look valid
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask
    // Word as two byte writes, upper byte first
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        wr(a + 7'h01, d[15:8]);
        wr(a, d[7:0]);
    endtask
    // Address parks on the word read; data is one cycle behind it
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        @(posedge clk_sys);
        #1 d = regRdData;
    endtask
endmodule
`default_nettype wire

// ### test/asm_alarm_status_asserts.sv
// Port-level checks for the alarm and status monitor
`timescale 1ns/1ns
`default_nettype none
module asm_alarm_status_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic regWrite,
    input wire logic [6:0] regAddr,
    input wire logic [15:0] regRdData,
    input wire logic sampleStrobe,
    input wire logic supplyHighPin,
    input wire logic supplyLowPin,
    input wire logic [1:0] gpioOwnsLine,
    input wire logic [1:0] readyOwnsLine,
    input wire logic [1:0] alarmLineOe,
    input wire logic captureTrigOne,
    input wire logic captureTrigTwo
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // Comparators pass two sync stages, the flag and the readback
    chk_supply_flags: assert property (
        ($stable({supplyHighPin, supplyLowPin}) && regAddr == 7'h3c)[*4]
        |=> regRdData[1:0] == $past({supplyHighPin, supplyLowPin})) else $error("supply flags stale");
    chk_status_spare: assert property (
        $past(regAddr) == 7'h3c |-> (regRdData & 16'hecd0) == 16'h0000) else $error("spare status bit set");
    chk_unmapped_zero: assert property (
        !($past(regAddr) inside {[7'h20:7'h23], 7'h28, 7'h29, [7'h3c:7'h3f]})
        |-> regRdData == 16'h0000) else $error("unmapped read not zero");
    // Clearing needs a write elsewhere, so a parked status read never sees a fall
    chk_sticky_hold: assert property (
        $past(regAddr) == 7'h3c && $past(regAddr, 2) == 7'h3c && $past(regAddr, 3) == 7'h3c
        |-> ($past(regRdData) & ~regRdData & 16'h132c) == 16'h0000) else $error("sticky flag fell");
    chk_trig_one: assert property (
        $rose(captureTrigOne) |-> $past(sampleStrobe, 2) || $past(regWrite) || $past(regWrite, 2))
        else $error("trigger one rose without cause");
    chk_trig_two: assert property (
        $changed(captureTrigTwo) |-> $past(sampleStrobe, 2) || $past(regWrite) || $past(regWrite, 2))
        else $error("trigger two moved without cause");
    chk_line_owned: assert property (
        (alarmLineOe & $past(gpioOwnsLine | readyOwnsLine)) == 2'b00) else $error("indicator on busy line");
    chk_oe_cause: assert property (
        $changed(alarmLineOe) |-> $past(regWrite) || $past(regWrite, 2)
        || $past(gpioOwnsLine | readyOwnsLine) != $past(gpioOwnsLine | readyOwnsLine, 2))
        else $error("enable moved without cause");
    chk_reset_quiet: assert property (
        $fell(sys_rst) |-> regRdData == 16'h0000 && alarmLineOe == 2'b00 && !captureTrigOne && !captureTrigTwo)
        else $error("outputs not quiet after reset");
endmodule
bind asm_alarm_status asm_alarm_status_asserts u_chk (.clk_sys, .sys_rst, .regWrite, .regAddr, .regRdData,
    .sampleStrobe, .supplyHighPin, .supplyLowPin, .gpioOwnsLine, .readyOwnsLine, .alarmLineOe,
    .captureTrigOne, .captureTrigTwo);
`default_nettype wire

// ### test/asm_tb.sv
// Self-checking bench for the alarm and status monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_sys, sys_rst, sampleStrobe, regWrite, supplyHighPin, supplyLowPin;
    logic captureTrigOne, captureTrigTwo, hit1, hit2, lvl;
    logic [6:0] regAddr;
    logic [7:0] regWrData;
    logic [15:0] regRdData, ctrl, th1, th2, got;
    logic [1:0] gpioOwnsLine, readyOwnsLine, alarmLineOut, alarmLineOe, oe;
    asm_pkg::asm_samples_t samples;
    asm_pkg::asm_errors_t errors;
    int miscompares, testsRun, cycles;
    logic [6:0] addrs [5] = '{7'h20, 7'h22, 7'h28, 7'h3c, 7'h10};
    asm_alarm_status u_dut (.clk_sys, .sys_rst, .regWrite, .regAddr, .regWrData, .regRdData,
        .sampleStrobe, .samples, .errors, .supplyHighPin, .supplyLowPin, .gpioOwnsLine,
        .readyOwnsLine, .alarmLineOut, .alarmLineOe, .captureTrigOne, .captureTrigTwo);
    asm_host_model u_host (.clk_sys, .regWrite, .regAddr, .regWrData, .regRdData);
    // ****************************************
    // Model and helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Unlisted source codes compare nothing, so they can never alarm
    function automatic logic hitOf(input logic [3:0] c, input logic [15:0] t);
        int val;
        case (c)
            4'h1: val = samples.supply;
            4'h2: val = samples.accelX;
            4'h3: val = samples.accelY;
            4'h4: val = samples.aux;
            4'h5: val = samples.temp;
            4'h8: val = samples.rss;
            default: return 1'b0;
        endcase
        return t[15] ? val > int'(t[13:0]) : val < int'(t[13:0]);
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, well above the roughly 1100 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h023733e3));
        {sys_rst, sampleStrobe, supplyHighPin, supplyLowPin} = 4'h8;
        {gpioOwnsLine, readyOwnsLine} = 4'h0;
        samples = '0;
        errors = '0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (addrs[k]) begin
            u_host.rd(addrs[k], got);
            chk(got, 16'h0000);
        end
        u_host.wr(7'h3d, 8'hff);
        u_host.rd(7'h3c, got);
        chk(got, 16'h0000);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            {supplyHighPin, supplyLowPin} <= 2'(1 << $urandom_range(2));
            // Lines stay free while i[2:1] is zero, as a careful host keeps them
            gpioOwnsLine <= i[1] ? 2'($urandom) : 2'b00;
            readyOwnsLine <= i[2] ? 2'($urandom) : 2'b00;
            errors <= 4'($urandom);
            samples <= 84'({$urandom, $urandom, $urandom});
            ctrl = {4'(i + 5), 4'(i), 8'($urandom)} & 16'hff57;
            th1 = 16'($urandom) & 16'hbfff;
            th2 = 16'($urandom) & 16'hbfff;
            u_host.wr16(7'h28, ctrl);
            u_host.wr16(7'h20, th1);
            u_host.wr16(7'h22, th2);
            u_host.rd(7'h29, got);
            chk(got, ctrl);
            u_host.rd(7'h21, got);
            chk(got, th1);
            u_host.rd(7'h23, got);
            chk(got, th2);
            u_host.wr(7'h3e, 8'h10);
            u_host.rd(7'h3c, got);
            chk(got, {14'h0000, supplyHighPin, supplyLowPin});
            @(posedge clk_sys);
            sampleStrobe <= 1'b1;
            @(posedge clk_sys);
            sampleStrobe <= 1'b0;
            hit1 = hitOf(ctrl[11:8], th1);
            hit2 = hitOf(ctrl[15:12], th2);
            u_host.rd(7'h3c, got);
            chk(got, {3'b000, errors.bufferFull, 2'b00, hit2, hit1, 2'b00, errors.selfTestFail, 1'b0,
                errors.serialFail, errors.flashFail, supplyHighPin, supplyLowPin});
            lvl = ctrl[1] ? (hit1 | hit2) : !(hit1 | hit2);
            oe = ctrl[0] ? 2'b10 : 2'b01;
            oe = (ctrl[2] && (oe & (gpioOwnsLine | readyOwnsLine)) == 2'b00) ? oe : 2'b00;
            chk({10'h000, alarmLineOe, alarmLineOut & alarmLineOe, captureTrigTwo, captureTrigOne},
                {10'h000, oe, oe & {2{lvl}}, hit2 & ctrl[6], hit1 & ctrl[4]});
            repeat (6) @(posedge clk_sys);
        end
        // Mid-run reset must wipe configuration, flags and outputs alike
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        {supplyHighPin, supplyLowPin} <= 2'b00;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk({12'h000, alarmLineOe, captureTrigTwo, captureTrigOne}, 16'h0000);
        foreach (addrs[k]) begin
            u_host.rd(addrs[k], got);
            chk(got, 16'h0000);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
